// File: rfrx_framing_ctrl.sv
// Receive framing control: protocol select, timers, collision report.
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`include "rfrx_defs.svh"
module rfrx_framing_ctrl import rfrx_pkg::*; (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Transmitter and slot events.
	input wire logic tx_end,
	input wire logic slot_start,
	input wire logic rx_start,
	// Bit decoder stream.
	input wire logic frame_start,
	input wire logic bit_valid,
	input wire logic bit_collision,
	input wire logic direct_mode,
	input wire logic subcarrier_in,
	input wire logic dec_bit,
	input wire logic dec_clk,
	// Framed receive bytes.
	input wire logic [7:0] rx_byte,
	input wire logic rx_byte_valid,
	input wire logic rx_byte_is_crc,
	// Receive FIFO write side.
	output logic [7:0] fifo_wdata,
	output logic fifo_wvalid,
	// Decoder configuration.
	output rfrx_cfg_t rx_cfg,
	output logic [1:0] tx_rate,
	output logic decoder_reset,
	// Direct mode outputs.
	output logic direct_data,
	output logic direct_clk,
	// Interrupt request.
	output logic irq
);
	rfrx_top_t r; // Registered state.
	rfrx_top_t next_r; // Next state.
	logic guard_busy; // Decoders held in reset.
	logic noresp_done; // Slot expired without answer.
	logic col_hit; // Collision located this cycle.
	logic [9:0] col_pos; // Latched collision bit number.
	logic setup; // APB setup phase.
	logic access; // APB access phase completing.
	logic [7:0] idx; // Register index from the byte address.
	logic mapped; // Index names a register.

	// Decodes a protocol register value into receiver settings.
	// It serves the live settings and both preset tables alike.
	function automatic rfrx_cfg_t decode(input logic [7:0] p);
		rfrx_cfg_t c;
		c = '0;
		// Reader mode is assumed; bit 5 is stored but not acted on.
		// Bits 4:3 pick the vicinity family and bits 4:2 a proximity type;
		// the bits below them give the variant within it.
		if (p[4:3] == 2'b00) begin
			// Eight vicinity variants share one decoder.
			c.family = RFRX_FAM_VIC;
		end else if (p[4:2] == 3'b010) begin
			// Type A at one of four rates.
			c.family = RFRX_FAM_PROX_A;
		end else if (p[4:2] == 3'b011) begin
			// Type B at one of four rates.
			c.family = RFRX_FAM_PROX_B;
		end else begin
			// Reserved and unsupported codes select no decoder.
			c.family = RFRX_FAM_NONE;
		end
		// Variant bits are forced low outside the vicinity family, so a
		// stale bit never reaches a decoder that is idle.
		c.vic_one_of_256 = (p[4:3] == 2'b00) && p[0];
		c.vic_high_rate = (p[4:3] == 2'b00) && p[1];
		c.vic_double_sub = (p[4:3] == 2'b00) && p[2];
		// Low two bits give 106, 212, 424 or 848 kbps on receive.
		c.rx_rate = (p[4:3] == 2'b01) ? p[1:0] : 2'b00;
		// The stored bit means skip; the framer wants the opposite sense.
		c.crc_check = !p[`RFRX_BIT_NO_CRC];
		c.dir_bitstream = p[`RFRX_BIT_DIR_KIND];
		return c;
	endfunction

	// Receive-wait preset for the minimum tag response time.
	function automatic logic [7:0] pre_wait(input logic [7:0] p);
		rfrx_cfg_t c;
		c = decode(p);
		if (c.family == RFRX_FAM_VIC) begin
			// Vicinity cards get the longer wait.
			return `RFRX_PRE_WAIT_VIC;
		end else if (c.family == RFRX_FAM_PROX_A) begin
			return `RFRX_PRE_WAIT_A;
		end else begin
			// Type B and the reserved codes share one preset.
			return `RFRX_PRE_WAIT_B;
		end
	endfunction

	// No-response preset per protocol.
	function automatic logic [7:0] pre_noresp(input logic [7:0] p);
		rfrx_cfg_t c;
		c = decode(p);
		if (c.family == RFRX_FAM_VIC) begin
			// Vicinity slots are allowed the longest silence.
			return `RFRX_PRE_NORESP_VIC;
		end else if (c.family == RFRX_FAM_PROX_A) begin
			return `RFRX_PRE_NORESP_A;
		end else begin
			// Type B and the reserved codes share one preset.
			return `RFRX_PRE_NORESP_B;
		end
	endfunction

	// Guard after transmit; restarted by every transmit end. The step is
	// rounded up, so the decoders are never let go before the wait ends;
	// the price is at most one clock of extra deafness per step.
	rfrx_step_timer #(
		.STEP(11'(`RFRX_GUARD_CYC))
	) u_guard (
		.pclk(pclk),
		.presetn(presetn),
		.start(tx_end),
		.cancel(1'b0),
		.steps(r.rx_wait),
		.busy(guard_busy),
		.done()
	);

	// Slot timer; a tag answer cancels it. The step is rounded down, so
	// an empty slot is never reported later than the limit allows.
	rfrx_step_timer #(
		.STEP(11'(`RFRX_NORESP_CYC))
	) u_noresp (
		.pclk(pclk),
		.presetn(presetn),
		.start(slot_start),
		.cancel(rx_start),
		.steps(r.no_resp),
		// Only the outcome of the slot timer is used.
		.busy(),
		.done(noresp_done)
	);

	// Collision reporting is active for type A only. Bits that arrive
	// during the guard are transients and are not numbered, so they
	// cannot shift the reported position.
	rfrx_collision u_coll (
		.pclk(pclk),
		.presetn(presetn),
		.frame_start(frame_start),
		.bit_valid(bit_valid && !guard_busy),
		.bit_collision(bit_collision),
		.enable(r.cfg.family == RFRX_FAM_PROX_A),
		.pos(col_pos),
		.hit(col_hit)
	);

	// APB phase and address decode. A misaligned byte address is refused
	// rather than rounded down, so a wrong pointer in software shows up.
	always_comb begin
		setup = psel && !penable;
		access = psel && penable;
		idx = {2'b00, paddr[7:2]};
		mapped = (paddr[1:0] == 2'b00) &&
			(idx == `RFRX_IDX_PROTOCOL || idx == `RFRX_IDX_RATE ||
			idx == `RFRX_IDX_NO_RESP || idx == `RFRX_IDX_RX_WAIT ||
			idx == `RFRX_IDX_IRQ_STATUS || idx == `RFRX_IDX_COL_MASK ||
			idx == `RFRX_IDX_COL_POS);
	end

	// Next-state logic for registers, status and outputs.
	always_comb begin
		next_r = r;
		// The slave answers in the cycle after setup, so pready stays high.
		// It is low only in reset, which keeps a master from finishing a
		// transfer while the registers are being preset.
		next_r.pready = 1'b1;
		// Read data and error are prepared in setup, shown in access.
		if (setup) begin
			next_r.pslverr = !mapped;
			// Unmapped indices and the upper bytes read as zero.
			next_r.prdata = 32'h00000000;
			if (idx == `RFRX_IDX_PROTOCOL) begin
				next_r.prdata[7:0] = r.protocol;
			end else if (idx == `RFRX_IDX_RATE) begin
				next_r.prdata[7:0] = r.rate;
			end else if (idx == `RFRX_IDX_NO_RESP) begin
				next_r.prdata[7:0] = r.no_resp;
			end else if (idx == `RFRX_IDX_RX_WAIT) begin
				next_r.prdata[7:0] = r.rx_wait;
			end else if (idx == `RFRX_IDX_IRQ_STATUS) begin
				// This copy is what the access phase later clears.
				next_r.prdata[1:0] = r.status;
			end else if (idx == `RFRX_IDX_COL_MASK) begin
				// The top position bits share a word with the mask bits.
				next_r.prdata[7:0] = {col_pos[9:8], r.mask};
			end else if (idx == `RFRX_IDX_COL_POS) begin
				next_r.prdata[7:0] = col_pos[7:0];
			end
		end
		// Writes take effect at the completing access edge.
		if (access && pwrite && !r.pslverr) begin
			if (idx == `RFRX_IDX_PROTOCOL) begin
				next_r.protocol = pwdata[7:0];
				// Later fine tuning must follow this write.
				next_r.rx_wait = pre_wait(pwdata[7:0]);
				next_r.no_resp = pre_noresp(pwdata[7:0]);
			end else if (idx == `RFRX_IDX_RATE) begin
				// Only bits 1:0 steer the transmitter; the rest are kept.
				next_r.rate = pwdata[7:0];
			end else if (idx == `RFRX_IDX_NO_RESP) begin
				// Overrides the preset until the next protocol write.
				next_r.no_resp = pwdata[7:0];
			end else if (idx == `RFRX_IDX_RX_WAIT) begin
				// Used at the next transmit end, not in a running guard.
				next_r.rx_wait = pwdata[7:0];
			end else if (idx == `RFRX_IDX_COL_MASK) begin
				// The position bits above the mask are read only.
				next_r.mask = pwdata[5:0];
			end
		end
		// Reading status clears only the bits that were returned, and a
		// new event in the same cycle is kept: the set wins.
		if (access && !pwrite && idx == `RFRX_IDX_IRQ_STATUS) begin
			next_r.status = r.status & ~r.prdata[1:0];
		end
		if (noresp_done) begin
			next_r.status[`RFRX_BIT_ST_NORESP] = 1'b1;
		end
		// The locator only reports while the type A family is selected.
		if (col_hit) begin
			next_r.status[`RFRX_BIT_ST_COLL] = 1'b1;
		end
		// Mask bit set blocks the matching status bit from the request.
		// The request follows the next status, so it rises with the flag.
		next_r.irq = |(next_r.status & ~next_r.mask[1:0]);
		// Decoding the next value keeps the settings in step with it.
		next_r.cfg = decode(next_r.protocol);
		// Transmit rate comes from the rate register alone.
		// The protocol code sets only the receive rate.
		next_r.tx_rate = next_r.rate[1:0];
		// Direct mode routes raw subcarrier or the decoder stream.
		if (direct_mode && r.cfg.dir_bitstream) begin
			next_r.direct_data = dec_bit;
			next_r.direct_clk = dec_clk;
		end else if (direct_mode) begin
			next_r.direct_data = subcarrier_in;
			// Raw subcarrier carries no clock of its own.
			next_r.direct_clk = 1'b0;
		end else begin
			// Outside direct mode both pins rest low.
			next_r.direct_data = 1'b0;
			next_r.direct_clk = 1'b0;
		end
		// CRC bytes are stripped when checked; bytes in guard are noise.
		// The byte is copied every cycle; only the strobe marks it new.
		next_r.fifo_wdata = rx_byte;
		next_r.fifo_wvalid = rx_byte_valid && !guard_busy &&
			!(rx_byte_is_crc && r.cfg.crc_check);
	end

	// State register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// Only constants are loaded here, so the reset branch never
			// depends on logic that is itself being reset.
			r <= '0;
			r.protocol <= `RFRX_RST_PROTOCOL;
			r.rate <= `RFRX_RST_RATE;
			r.rx_wait <= `RFRX_PRE_WAIT_VIC;
			r.no_resp <= `RFRX_PRE_NORESP_VIC;
			r.mask <= `RFRX_RST_MASK;
			// The decoded settings are registered, so they are preset to
			// match the default code instead of lagging one cycle.
			r.cfg.family <= RFRX_FAM_VIC;
			r.cfg.vic_high_rate <= 1'b1;
			r.cfg.crc_check <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	// Outputs straight from flip-flops.
	// The decoder reset comes from the guard timer's own flip-flop.
	assign prdata = r.prdata;
	assign pready = r.pready;
	assign pslverr = r.pslverr;
	assign irq = r.irq;
	assign rx_cfg = r.cfg;
	assign tx_rate = r.tx_rate;
	assign decoder_reset = guard_busy;
	assign direct_data = r.direct_data;
	assign direct_clk = r.direct_clk;
	assign fifo_wdata = r.fifo_wdata;
	assign fifo_wvalid = r.fifo_wvalid;
endmodule // rfrx_framing_ctrl

// File: rfrx_defs.svh
// Constants of the receive framing control block.
//Function
//- Top bit one skips received CRC checking.
//- Direct-kind bit picks subcarrier or decoder stream.
//- Codes 00000-00111 select vicinity coding variants.
//- Default protocol code is 00010.
//- Codes 01000-01011 select type A rates.
//- Codes 01100-01111 select type B rates.
//- Proximity code rate governs receive rate only.
//- Type A collision raises request and flag.
//- Collision position split over two registers.
//- Position counts bits from zero after start.
//- Guard holds decoders reset after transmit.
//- Protocol write presets the receive-wait register.
//- Empty slot raises request and no-response flag.
//- No-response limit is value times 37.76us.
//- Protocol selection presets the no-response register.
//- Protocol write reloads all related defaults.
//- Strip CRC, pass clean bytes to FIFO.
`ifndef RFRX_DEFS_SVH
`define RFRX_DEFS_SVH
// Register indices; the byte address is four times the index.
`define RFRX_IDX_PROTOCOL 8'h01
`define RFRX_IDX_RATE 8'h03
`define RFRX_IDX_NO_RESP 8'h07
`define RFRX_IDX_RX_WAIT 8'h08
`define RFRX_IDX_IRQ_STATUS 8'h0C
`define RFRX_IDX_COL_MASK 8'h0D
`define RFRX_IDX_COL_POS 8'h0E
// Field positions.
`define RFRX_BIT_NO_CRC 7
`define RFRX_BIT_DIR_KIND 6
`define RFRX_BIT_READER 5
`define RFRX_BIT_ST_NORESP 0
`define RFRX_BIT_ST_COLL 1
// Reset values.
`define RFRX_RST_PROTOCOL 8'h02
`define RFRX_RST_RATE 8'h00
`define RFRX_RST_MASK 6'h00
// Presets per protocol family.
`define RFRX_PRE_WAIT_VIC 8'h1F
`define RFRX_PRE_WAIT_A 8'h0E
`define RFRX_PRE_WAIT_B 8'h0E
`define RFRX_PRE_NORESP_VIC 8'h10
`define RFRX_PRE_NORESP_A 8'h0E
`define RFRX_PRE_NORESP_B 8'h0E
// Timer steps in picoseconds and the clock period.
`define RFRX_CLK_PS 25000
`define RFRX_GUARD_STEP_PS 9440000
`define RFRX_NORESP_STEP_PS 37760000
// Guard is a least time (round up), no-response a longest (round down).
`define RFRX_GUARD_CYC \
	((`RFRX_GUARD_STEP_PS + `RFRX_CLK_PS - 1) / `RFRX_CLK_PS)
`define RFRX_NORESP_CYC (`RFRX_NORESP_STEP_PS / `RFRX_CLK_PS)
`endif

// File: rfrx_pkg.sv
// Types of the receive framing control block.
package rfrx_pkg;
	// Protocol family decoded from the code bits.
	typedef enum logic [1:0] {
		RFRX_FAM_NONE = 2'b00,
		RFRX_FAM_VIC = 2'b01,
		RFRX_FAM_PROX_A = 2'b10,
		RFRX_FAM_PROX_B = 2'b11
	} rfrx_family_t;
	// Decoded receiver configuration.
	typedef struct packed {
		rfrx_family_t family;
		logic vic_one_of_256;
		logic vic_high_rate;
		logic vic_double_sub;
		logic [1:0] rx_rate;
		logic crc_check;
		logic dir_bitstream;
	} rfrx_cfg_t;
	// State of a step timer.
	typedef struct packed {
		logic [10:0] pre;
		logic [7:0] cnt;
		logic busy;
		logic done;
	} rfrx_tmr_t;
	// State of the collision locator.
	typedef struct packed {
		logic [9:0] count;
		logic [9:0] pos;
		logic hit;
	} rfrx_col_t;
	// State of the top block.
	typedef struct packed {
		logic [7:0] protocol;
		logic [7:0] rate;
		logic [7:0] no_resp;
		logic [7:0] rx_wait;
		logic [1:0] status;
		logic [5:0] mask;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic irq;
		rfrx_cfg_t cfg;
		logic [1:0] tx_rate;
		logic direct_data;
		logic direct_clk;
		logic [7:0] fifo_wdata;
		logic fifo_wvalid;
	} rfrx_top_t;
endpackage

// File: rfrx_step_timer.sv
// Step timer: counts a register value in steps of STEP clock cycles.
`timescale 1ns/1ps
module rfrx_step_timer import rfrx_pkg::*; #(
	parameter logic [10:0] STEP = 11'h17A
) (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Control.
	input wire logic start,
	input wire logic cancel,
	input wire logic [7:0] steps,
	// Status.
	output logic busy,
	output logic done
);
	rfrx_tmr_t r; // Registered state.
	rfrx_tmr_t next_r; // Next state.

	// A zero value disables the interval; a start restarts it.
	always_comb begin
		next_r = r;
		next_r.done = 1'b0;
		if (start) begin
			// A new interval begins from a full prescaler.
			next_r.pre = STEP - 11'h001;
			next_r.cnt = steps;
			next_r.busy = (steps != 8'h00);
		end else if (cancel) begin
			// The awaited event arrived in time.
			next_r.busy = 1'b0;
		end else if (r.busy) begin
			if (r.pre != 11'h000) begin
				next_r.pre = r.pre - 11'h001;
			end else begin
				// One whole step has passed.
				next_r.pre = STEP - 11'h001;
				next_r.cnt = r.cnt - 8'h01;
				if (r.cnt == 8'h01) begin
					next_r.busy = 1'b0;
					next_r.done = 1'b1;
				end
			end
		end
	end

	// State register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign busy = r.busy;
	assign done = r.done;
endmodule // rfrx_step_timer

// File: rfrx_collision.sv
// Collision locator: numbers received bits and latches a collision.
`timescale 1ns/1ps
module rfrx_collision import rfrx_pkg::*; (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Receive bit events.
	input wire logic frame_start,
	input wire logic bit_valid,
	input wire logic bit_collision,
	input wire logic enable,
	// Result.
	output logic [9:0] pos,
	output logic hit
);
	rfrx_col_t r; // Registered state.
	rfrx_col_t next_r; // Next state.

	// Bits are numbered from zero right after the start bit, so the
	// command and valid_bits_count_byte take numbers 0 to 15.
	always_comb begin
		next_r = r;
		next_r.hit = 1'b0;
		if (frame_start) begin
			next_r.count = 10'h000;
		end else if (bit_valid) begin
			if (bit_collision && enable) begin
				next_r.pos = r.count;
				next_r.hit = 1'b1;
			end
			// Long frames wrap; only ten bits are reported.
			next_r.count = r.count + 10'h001;
		end
	end

	// State register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign pos = r.pos;
	assign hit = r.hit;
endmodule // rfrx_collision

// File: rfrx_framing_ctrl_asserts.sv
// Port checker of the receive framing control block.
`timescale 1ns/1ps
module rfrx_framing_ctrl_asserts import rfrx_pkg::*; (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Register port.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pslverr,
	// Receive path.
	input wire logic tx_end,
	input wire logic decoder_reset,
	input wire logic [7:0] rx_byte,
	input wire logic rx_byte_valid,
	input wire logic rx_byte_is_crc,
	input wire logic [7:0] fifo_wdata,
	input wire logic fifo_wvalid,
	input wire rfrx_cfg_t rx_cfg,
	// Direct mode.
	input wire logic direct_mode,
	input wire logic subcarrier_in,
	input wire logic dec_bit,
	input wire logic dec_clk,
	input wire logic direct_data,
	input wire logic direct_clk
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// A protocol write lands at the access edge.
	logic pw;
	logic map;
	assign pw = psel && penable && pwrite && paddr == 8'h04;
	assign map = paddr inside {8'h04, 8'h0C, 8'h1C, 8'h20, 8'h30, 8'h34,
		8'h38};
	property p_err;
		psel && penable && !map |-> pslverr;
	endproperty
	a_err: assert property (p_err) else $error("no slave error");
	property p_crc;
		pw |-> ##2 rx_cfg.crc_check == !$past(pwdata[7], 2);
	endproperty
	a_crc: assert property (p_crc) else $error("crc check wrong");
	property p_vic;
		pw && pwdata[4:3] == 2'b00 |-> ##2 rx_cfg.family == RFRX_FAM_VIC &&
		{rx_cfg.vic_double_sub, rx_cfg.vic_high_rate,
		rx_cfg.vic_one_of_256} == $past(pwdata[2:0], 2);
	endproperty
	a_vic: assert property (p_vic) else $error("vicinity decode");
	property p_prox;
		pw && pwdata[4:3] == 2'b01 |-> ##2
		rx_cfg.rx_rate == $past(pwdata[1:0], 2) && rx_cfg.family ==
		($past(pwdata[2], 2) ? RFRX_FAM_PROX_B : RFRX_FAM_PROX_A);
	endproperty
	a_prox: assert property (p_prox) else $error("prox decode");
	property p_guard;
		$rose(decoder_reset) |-> $past(tx_end);
	endproperty
	a_guard: assert property (p_guard) else $error("guard cause");
	property p_fifo;
		rx_byte_valid && !rx_byte_is_crc |=>
		fifo_wvalid && fifo_wdata == $past(rx_byte);
	endproperty
	a_fifo: assert property (p_fifo) else $error("byte lost");
	property p_strip;
		rx_byte_valid && rx_byte_is_crc && rx_cfg.crc_check |=> !fifo_wvalid;
	endproperty
	a_strip: assert property (p_strip) else $error("crc passed");
	property p_sub;
		direct_mode && !rx_cfg.dir_bitstream |=>
		direct_data == $past(subcarrier_in);
	endproperty
	a_sub: assert property (p_sub) else $error("subcarrier out");
	property p_dec;
		direct_mode && rx_cfg.dir_bitstream |=>
		direct_data == $past(dec_bit) && direct_clk == $past(dec_clk);
	endproperty
	a_dec: assert property (p_dec) else $error("decoder out");
endmodule // rfrx_framing_ctrl_asserts
bind rfrx_framing_ctrl rfrx_framing_ctrl_asserts chk_u (.*);

// File: rfrx_host_model.sv
// Host model: an APB master driven by the bench through one task.
`timescale 1ns/1ps
module rfrx_host_model (
	// Clock.
	input wire logic pclk,
	// APB master side.
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end
	// One transfer; the reader-mode bit is kept clear in protocol writes.
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= (a == 8'h04) ? (d & ~32'h20) : d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		r = prdata;
		e = pslverr;
		// A released bus shows the inverse, so stale values never match.
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
	endtask
endmodule // rfrx_host_model

// File: rfrx_rx_framing_control_tb.sv
// Self-checking bench of the receive framing control block.
`timescale 1ns/1ps
`include "rfrx_defs.svh"
`define CHK(n, e, s) chk(n, 32'(e), 32'(s))
module rfrx_rx_framing_control_tb import rfrx_pkg::*;;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [7:0] paddr, rx_byte, fifo_wdata, d;
	logic [31:0] pwdata, prdata, rd, lf;
	logic tx_end, slot_start, rx_start, frame_start, bit_valid;
	logic bit_collision, direct_mode, subcarrier_in, dec_bit, dec_clk;
	logic rx_byte_valid, rx_byte_is_crc, fifo_wvalid, decoder_reset;
	logic direct_data, direct_clk, irq;
	logic [1:0] tx_rate;
	rfrx_cfg_t rx_cfg;
	int c, i, n, fails, checked;
	logic [7:0] q[$];
	rfrx_framing_ctrl dut_u (.*);
	rfrx_host_model host_u (.*);
	initial pclk = 1'b0;
	always #12.5 pclk = ~pclk;
	task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
		checked++;
		if (e !== s) begin
			fails++;
			$display("BAD %s exp %0h got %0h", nm, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		host_u.xfer(1'b1, a, v, rd, er);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, string s);
		host_u.xfer(1'b0, a, 32'h0, rd, er);
		`CHK(s, e, rd);
	endtask
	// Expected family for a protocol code.
	function automatic rfrx_family_t fam(input logic [4:0] k);
		return k[4:3] == 2'b00 ? RFRX_FAM_VIC :
			(k[2] ? RFRX_FAM_PROX_B : RFRX_FAM_PROX_A);
	endfunction
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic tend(string s);
		$display("test %s finished", s);
	endtask
	task automatic test_done();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// Watchdog: the tests need well under 10000 cycles.
	initial begin
		#1000000;
		fails++;
		test_done();
	end
	initial begin
		{presetn, tx_end, slot_start, rx_start, frame_start} = 5'h00;
		{bit_valid, bit_collision, direct_mode, subcarrier_in} = 4'h0;
		{dec_bit, dec_clk, rx_byte_valid, rx_byte_is_crc} = 4'h0;
		rx_byte = 8'h00;
		lf = 32'h8104;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		rdc(8'h04, 32'h02, "protocol");
		`CHK("ready", 1'b1, pready);
		`CHK("fam", RFRX_FAM_VIC, rx_cfg.family);
		`CHK("high", 1'b1, rx_cfg.vic_high_rate);
		rdc(8'h40, 32'h0, "unmapped");
		`CHK("err", 1'b1, er);
		tend("reset");
		for (c = 0; c < 16; c++) begin
			lf = lfsr(lf);
			d = {lf[1:0], 1'b0, c[4:0]};
			wr(8'h04, {24'h0, d});
			repeat (2) @(posedge pclk);
			`CHK("crc", !d[7], rx_cfg.crc_check);
			`CHK("fam", fam(c[4:0]), rx_cfg.family);
			if (c < 8) `CHK("vic", c[2:0], {rx_cfg.vic_double_sub,
				rx_cfg.vic_high_rate, rx_cfg.vic_one_of_256});
			else `CHK("rate", c[1:0], rx_cfg.rx_rate);
			rdc(8'h20, c < 8 ? `RFRX_PRE_WAIT_VIC : c < 12 ?
				`RFRX_PRE_WAIT_A : `RFRX_PRE_WAIT_B,
				"wait");
			rdc(8'h1C, c < 8 ? `RFRX_PRE_NORESP_VIC : c < 12 ?
				`RFRX_PRE_NORESP_A : `RFRX_PRE_NORESP_B,
				"noresp");
		end
		wr(8'h0C, 32'h1);
		repeat (2) @(posedge pclk);
		`CHK("tx", 2'h1, tx_rate);
		`CHK("rx", 2'h3, rx_cfg.rx_rate);
		tend("protocols");
		wr(8'h04, 32'h08);
		{direct_mode, subcarrier_in, dec_bit, dec_clk} <= 4'hC;
		repeat (3) @(posedge pclk);
		`CHK("sub", 1'b1, direct_data);
		`CHK("sclk", 1'b0, direct_clk);
		wr(8'h04, 32'h48);
		{subcarrier_in, dec_bit, dec_clk} <= 3'h3;
		repeat (3) @(posedge pclk);
		`CHK("dbit", 1'b1, direct_data);
		`CHK("dclk", 1'b1, direct_clk);
		direct_mode <= 1'b0;
		tend("direct");
		// Fine tuning follows the protocol write, which would undo it.
		wr(8'h04, 32'h08);
		wr(8'h34, 32'h3C);
		wr(8'h20, 32'h02);
		wr(8'h1C, 32'h01);
		for (i = 0; i < 4; i++) begin
			@(posedge pclk);
			lf = lfsr(lf);
			rx_byte <= lf[7:0];
			rx_byte_is_crc <= i[0];
			rx_byte_valid <= 1'b1;
			if (!i[0]) q.push_back(lf[7:0]);
			@(posedge pclk);
			rx_byte_valid <= 1'b0;
			#1;
			`CHK("wvalid", !i[0], fifo_wvalid);
			if (fifo_wvalid === 1'b1) `CHK("wdata", q.pop_front(),
				fifo_wdata);
		end
		tend("fifo");
		@(posedge pclk);
		tx_end <= 1'b1;
		@(posedge pclk);
		tx_end <= 1'b0;
		n = 0;
		repeat (900) begin
			@(posedge pclk);
			if (decoder_reset === 1'b1) n++;
		end
		`CHK("guard", 2 * `RFRX_GUARD_CYC, n);
		tend("guard");
		@(posedge pclk);
		frame_start <= 1'b1;
		for (i = 0; i < 17; i++) begin
			@(posedge pclk);
			frame_start <= 1'b0;
			bit_valid <= 1'b1;
			bit_collision <= (i == 16);
		end
		@(posedge pclk);
		{bit_valid, bit_collision} <= 2'b00;
		repeat (4) @(posedge pclk);
		#1;
		`CHK("irq", 1'b1, irq);
		rdc(8'h38, 32'h10, "colpos");
		rdc(8'h34, 32'h3C, "colhi");
		rdc(8'h30, 32'h02, "status");
		tend("collision");
		@(posedge pclk);
		slot_start <= 1'b1;
		@(posedge pclk);
		slot_start <= 1'b0;
		n = 0;
		while (irq !== 1'b1 && n < 3000) begin
			@(posedge pclk);
			n++;
		end
		`CHK("limit", 1'b1, n >= 1510 && n <= 1514);
		rdc(8'h30, 32'h01, "status");
		@(posedge pclk);
		slot_start <= 1'b1;
		@(posedge pclk);
		slot_start <= 1'b0;
		repeat (100) @(posedge pclk);
		rx_start <= 1'b1;
		@(posedge pclk);
		rx_start <= 1'b0;
		repeat (1700) @(posedge pclk);
		`CHK("cancel", 1'b0, irq);
		tend("noresponse");
		test_done();
	end
endmodule // rfrx_rx_framing_control_tb
